// file: tone_transceiver_host_port_tb_top.sv
// testbench for the tone transceiver host port
`timescale 1ns/1ps
`default_nettype none
module tone_transceiver_host_port_tb_top;
    import tth_pkg::*;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, se;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        rx_valid, tone_absent, tone_present, tone_on;
    logic [3:0]  rx_code, tone_code, ctrl_a, ctrl_b;
    int          err_count, compares;

    tth_if bus ();
    tth_device #(.BURST_CYCLES(20), .BURST_CP_CYCLES(40)) i_tth_device (
        .sys_clk(sys_clk), .rst(rst), .bus(bus), .rx_valid(rx_valid),
        .rx_code(rx_code), .tone_absent(tone_absent),
        .tone_present(tone_present), .tone_on(tone_on),
        .tone_code(tone_code), .ctrl_a(ctrl_a), .ctrl_b(ctrl_b));
    tth_host i_tth_host (.sys_clk(sys_clk), .rst(rst), .bus(bus),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));
    tth_chk i_tth_chk (.sys_clk(sys_clk), .rst(rst),
        .register_select_line(bus.register_select_line),
        .rd_n(bus.rd_n), .wr_n(bus.wr_n), .host_d_out(bus.host_d_out),
        .host_d_oe(bus.host_d_oe), .dev_d_out(bus.dev_d_out),
        .dev_d_oe(bus.dev_d_oe),
        .interrupt_or_tone_pin_n_oe(bus.interrupt_or_tone_pin_n_oe));

    task automatic end_sim();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic fail(input string nm);
        err_count++;
        $display("wrong value %s expected done seen timeout", nm);
        end_sim();
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fail("pready");
        rv = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // issue a port command and poll until busy drops
    task automatic cmd(input logic [2:0] c, input logic [3:0] d);
        int n;
        apb(1'b1, OFS_WDATA, {28'h0, d});
        apb(1'b1, OFS_CMD, {29'h0, c});
        n = 0;
        do begin
            apb(1'b0, OFS_CMD, 32'h0);
            n++;
        end while (rv[3] !== 1'b0 && n < 100);
        if (rv[3] !== 1'b0) fail("busy");
    endtask
    task automatic st(input logic [3:0] e);
        cmd(CMD_RD_STATUS, 4'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("event_flags", rv[3:0], e);
    endtask
    task automatic wirq(input logic v, input int lim);
        int n;
        n = 0;
        while (bus.interrupt_or_tone_pin_n_oe !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (bus.interrupt_or_tone_pin_n_oe !== v) fail("interrupt pin");
        chk("interrupt pin", bus.interrupt_or_tone_pin_n_oe, v);
    endtask
    // 0: received digit, 1: tone absent, 2: tone present
    task automatic pulse(input int k, input logic [3:0] c);
        rx_code <= c;
        rx_valid <= (k == 0);
        tone_absent <= (k == 1);
        tone_present <= (k == 2);
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        tone_absent <= 1'b0;
        tone_present <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic t_init();
        cmd(CMD_INIT, 4'h0);
        chk("ctrl_b", ctrl_b, 4'h0);
        chk("ctrl_a", ctrl_a, CTRL_INIT_B);
        st(4'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", se, 1'b1);
        $display("test init done");
    endtask
    task automatic t_bank();
        cmd(CMD_WR_CTRL, 4'h8);
        cmd(CMD_WR_CTRL, 4'h1);
        chk("ctrl_b", ctrl_b, 4'h1);
        chk("ctrl_a", ctrl_a, 4'h8);
        cmd(CMD_WR_CTRL, 4'h4);
        chk("ctrl_a", ctrl_a, 4'h4);
        chk("ctrl_b", ctrl_b, 4'h1);
        $display("test bank done");
    endtask
    task automatic t_rx();
        pulse(0, 4'h9);
        wirq(1'b1, 20);
        st(4'h5);
        wirq(1'b0, 20);
        cmd(CMD_RD_RX, 4'h0);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk("rx digit", rv[3:0], 4'h9);
        st(4'h0);
        $display("test receive done");
    endtask
    task automatic t_settle();
        pulse(1, 4'h0);
        st(4'h8);
        pulse(2, 4'h0);
        st(4'h0);
        $display("test presence done");
    endtask
    task automatic t_noburst();
        cmd(CMD_WR_TX, 4'h3);
        repeat (60) @(posedge sys_clk);
        chk("tone_on", tone_on, 1'b0);
        st(4'h0);
        $display("test non-burst done");
    endtask
    task automatic t_burst();
        cmd(CMD_BURST_CFG, 4'h0);
        chk("ctrl_a", ctrl_a, CTRL_A_BURST);
        chk("ctrl_b", ctrl_b, 4'h0);
        cmd(CMD_WR_TX, 4'h7);
        chk("tone_on", tone_on, 1'b1);
        chk("tone_code", tone_code, 4'h7);
        wirq(1'b1, 100);
        chk("tone_on", tone_on, 1'b0);
        st(4'h3);
        wirq(1'b0, 20);
        cmd(CMD_WR_TX, 4'h5);
        chk("tone_code", tone_code, 4'h5);
        wirq(1'b1, 100);
        st(4'h3);
        st(4'h0);
        $display("test burst done");
    endtask
    // call progress mode: doubled burst, no interrupt on tx empty
    task automatic t_cp();
        cmd(CMD_WR_CTRL, 4'h7);
        chk("ctrl_a", ctrl_a, 4'h7);
        cmd(CMD_WR_TX, 4'h2);
        repeat (20) @(posedge sys_clk);
        chk("tone_on", tone_on, 1'b1);
        repeat (60) @(posedge sys_clk);
        wirq(1'b0, 1);
        st(4'h3);
        $display("test call progress done");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_valid, tone_absent, tone_present, rx_code} = '0;
        err_count = 0;
        compares = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_init();
        t_bank();
        t_rx();
        t_settle();
        t_noburst();
        t_burst();
        t_cp();
        end_sim();
    end
endmodule // tone_transceiver_host_port_tb_top
`default_nettype wire

// file: tth_chk.sv
// interface checker for the tone transceiver host port
`timescale 1ns/1ps
`default_nettype none
module tth_chk (
    input  wire logic       sys_clk,                    // clock
    input  wire logic       rst,                        // reset
    input  wire logic       register_select_line,       // select
    input  wire logic       rd_n,                       // read strobe
    input  wire logic       wr_n,                       // write strobe
    input  wire logic [3:0] host_d_out,                 // host data
    input  wire logic       host_d_oe,                  // host enable
    input  wire logic [3:0] dev_d_out,                  // device data
    input  wire logic       dev_d_oe,                   // device enable
    input  wire logic       interrupt_or_tone_pin_n_oe  // pin pulled
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_one_strobe: assert property (rd_n || wr_n)
        else $error("read and write strobes low together");
    a_read_answer: assert property ($fell(rd_n) |-> ##[1:4] dev_d_oe)
        else $error("device did not drive read data");
    a_read_release: assert property ($rose(rd_n) |-> ##[1:5] !dev_d_oe)
        else $error("device kept driving after read");
    a_dev_quiet: assert property (rd_n [*8] |-> !dev_d_oe)
        else $error("device drives bus without read");
    a_write_host: assert property (!wr_n |-> host_d_oe && !dev_d_oe)
        else $error("write without host data on bus");
    a_write_held: assert property ((!wr_n && $past(!wr_n)) |->
        $stable(host_d_out) && $stable(register_select_line))
        else $error("write data or select moved in strobe");
    a_read_len: assert property ($fell(rd_n) |-> (!rd_n) [*4])
        else $error("read strobe too short");
    a_summary_bit: assert property ((register_select_line && !rd_n &&
        dev_d_oe && |dev_d_out[2:1]) |-> dev_d_out[0])
        else $error("summary flag clear while event flag set");

    c_status_rd: cover property (register_select_line && $fell(rd_n));
    c_data_rd: cover property (!register_select_line && $fell(rd_n));
    c_data_wr: cover property (!register_select_line && $fell(wr_n));
    c_pin_low: cover property ($rose(interrupt_or_tone_pin_n_oe));
endmodule // tth_chk
`default_nettype wire

// file: tth_device.sv
// transceiver end: status flags, control registers, burst timer
// Notes on behaviour
// - summary bit follows bits 1/2, cleared on read
// - burst mode sets tx empty after pause
// - tx empty cleared on read, held off outside burst
// - rx full set on valid digit, cleared on read
// - settled presence bit set on absence, cleared on tone
// - select high: read status, write control
// - select low write loads transmit digit
// - host init sequence of control writes
// - host configures A then B for bursts
// - host waits interrupt or polls, then reads
// - tx empty seen, host writes next digit
// - rx full seen, host fetches received digit
// - bank b selected for exactly one write
// - interrupt low on rx digit or tx ready
// - control b bit0 low enables timed bursts
// - control a bit0 gates all tone output
`timescale 1ns/1ps
`default_nettype none
module tth_device
    import tth_pkg::*;
#(
    parameter int BURST_CYCLES    = tth_pkg::BURST_CYC,
    parameter int BURST_CP_CYCLES = tth_pkg::BURST_CP_CYC
) (
    input  wire logic        sys_clk,        // 100 mhz clock
    input  wire logic        rst,            // async reset, high
    tth_if.dev               bus,            // host parallel port
    input  wire logic        rx_valid,       // pulse: valid digit decoded
    input  wire logic [3:0]  rx_code,        // decoded digit code
    input  wire logic        tone_absent,    // pulse: absence validated
    input  wire logic        tone_present,   // pulse: tone pair validated
    output logic             tone_on,        // generator running
    output logic [3:0]       tone_code,      // digit being sent
    output logic [3:0]       ctrl_a,         // control register a
    output logic [3:0]       ctrl_b          // control register b
);
    import tth_pkg::*;

    // pin synchronisers
    logic [1:0] rs_s, rd_s, wr_s;
    logic [3:0] d_s1, d_s2;
    logic       rd_q, wr_q;
    logic [3:0] flags, next_flags;
    logic [3:0] next_ctrl_a, next_ctrl_b, rx_data, next_rx_data;
    logic [3:0] tx_data, next_tx_data, dout, next_dout;
    logic       bank_b, next_bank_b, oe, next_oe;
    tth_burst_t bst, next_bst;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic       tx_start, burst_mode, rd_fall, rd_rise, wr_rise;
    logic [CNT_W-1:0] dur;
    logic       next_tone_on;
    logic [3:0] next_tone_code;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rs_s <= '0;
            rd_s <= 2'h3;
            wr_s <= 2'h3;
            d_s1 <= ZERO4;
            d_s2 <= ZERO4;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
        end else begin
            rs_s <= {rs_s[0], bus.register_select_line};
            rd_s <= {rd_s[0], bus.rd_n};
            wr_s <= {wr_s[0], bus.wr_n};
            d_s1 <= bus.host_d_out;
            d_s2 <= d_s1;
            rd_q <= rd_s[1];
            wr_q <= wr_s[1];
        end
    end

    assign rd_fall = rd_q & ~rd_s[1];
    assign rd_rise = ~rd_q & rd_s[1];
    assign wr_rise = ~wr_q & wr_s[1];
    assign burst_mode = ~ctrl_b[CB_BURST_OFF];
    assign dur = ctrl_a[CA_CP] ? CNT_W'(BURST_CP_CYCLES)
                               : CNT_W'(BURST_CYCLES);

    // register access and flags
    always_comb begin
        next_flags   = flags;
        next_ctrl_a  = ctrl_a;
        next_ctrl_b  = ctrl_b;
        next_bank_b  = bank_b;
        next_tx_data = tx_data;
        next_rx_data = rx_data;
        next_dout    = dout;
        next_oe      = oe;
        tx_start     = 1'b0;
        if (rd_fall) begin
            next_oe = 1'b1;
            next_dout = rs_s[1] ? flags : rx_data;
        end
        if (rd_rise) begin
            next_oe = 1'b0;
            if (rs_s[1]) begin
                next_flags[FLAG_IRQ] = 1'b0;
                next_flags[FLAG_TXE] = 1'b0;
                next_flags[FLAG_RXF] = 1'b0;
            end
        end
        if (wr_rise) begin
            if (rs_s[1]) begin
                if (bank_b) begin
                    next_ctrl_b = d_s2;
                    next_bank_b = 1'b0;
                end else begin
                    next_ctrl_a = d_s2;
                    next_bank_b = d_s2[CA_BSEL];
                end
            end else begin
                next_tx_data = d_s2;
                tx_start = 1'b1;
            end
        end
        // hardware sets win over read clears
        if (rx_valid) begin
            next_rx_data = rx_code;
            next_flags[FLAG_RXF] = 1'b1;
        end
        if (bst == TTH_B_PAUSE && cnt == '0 && burst_mode)
            next_flags[FLAG_TXE] = 1'b1;
        if (!burst_mode)
            next_flags[FLAG_TXE] = 1'b0;
        // rx digit and tx empty set events re-arm the summary, even over a read clear; settled presence does not
        if (rx_valid || (bst == TTH_B_PAUSE && cnt == '0 && burst_mode))
            next_flags[FLAG_IRQ] = 1'b1;
        if (tone_absent)
            next_flags[FLAG_SETTL] = 1'b1;
        else if (tone_present)
            next_flags[FLAG_SETTL] = 1'b0;
    end

    // burst timer
    always_comb begin
        next_bst = bst;
        next_cnt = cnt;
        unique case (bst)
            TTH_B_IDLE: begin
                if (tx_start && burst_mode) begin
                    next_bst = TTH_B_TONE;
                    next_cnt = dur - CNT_W'(1);
                end
            end
            TTH_B_TONE: begin
                if (cnt == '0) begin
                    next_bst = TTH_B_PAUSE;
                    next_cnt = dur - CNT_W'(1);
                end else
                    next_cnt = cnt - CNT_W'(1);
            end
            TTH_B_PAUSE: begin
                if (cnt == '0)
                    next_bst = TTH_B_IDLE;
                else
                    next_cnt = cnt - CNT_W'(1);
            end
        endcase
        if (!burst_mode)
            next_bst = TTH_B_IDLE;
    end

    // tone generator drive
    always_comb begin
        next_tone_code = tx_data;
        next_tone_on   = ctrl_a[CA_TONE] &
                         (burst_mode ? (bst == TTH_B_TONE) : 1'b1);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags <= ZERO4;
            ctrl_a <= ZERO4;
            ctrl_b <= ZERO4;
            bank_b <= 1'b0;
            tx_data <= ZERO4;
            rx_data <= ZERO4;
            dout <= ZERO4;
            oe <= 1'b0;
            bst <= TTH_B_IDLE;
            cnt <= '0;
            tone_on <= 1'b0;
            tone_code <= ZERO4;
        end else begin
            flags <= next_flags;
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            bank_b <= next_bank_b;
            tx_data <= next_tx_data;
            rx_data <= next_rx_data;
            dout <= next_dout;
            oe <= next_oe;
            bst <= next_bst;
            cnt <= next_cnt;
            tone_on <= next_tone_on;
            tone_code <= next_tone_code;
        end
    end

    assign bus.dev_d_out = dout;
    assign bus.dev_d_oe  = oe;
    // open-drain interrupt, pulled low while enabled event pending, never in call progress mode
    assign bus.interrupt_or_tone_pin_n_oe = ctrl_a[CA_IRQEN] &
        ~ctrl_a[CA_CP] & (flags[FLAG_RXF] |
        (burst_mode & flags[FLAG_TXE]));
endmodule // tth_device
`default_nettype wire

// file: tth_host.sv
// host end: apb command registers driving the parallel port
`timescale 1ns/1ps
`default_nettype none
module tth_host
    import tth_pkg::*;
(
    input  wire logic        sys_clk,   // 100 mhz clock
    input  wire logic        rst,       // async reset, high
    tth_if.host              bus,       // device parallel port
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb enable
    input  wire logic        pwrite,    // apb direction
    input  wire logic [7:0]  paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic             pready,    // apb ready
    output logic [31:0]      prdata,    // apb read data
    output logic             pslverr    // apb error
);
    import tth_pkg::*;

    typedef enum logic [2:0] {TTH_H_IDLE, TTH_H_RUN, TTH_H_DONE}
        tth_seq_t;
    logic [1:0] irq_s;
    logic [3:0] d_s1, d_s2;
    tth_bus_t  bst, next_bst;
    tth_seq_t  hst, next_hst;
    logic [2:0] cmd, next_cmd, step, next_step;
    logic [3:0] wdat, next_wdat, stat, next_stat, rxd, next_rxd;
    logic [3:0] cyc, next_cyc;
    logic       busy, rs, next_rs, rdn, next_rdn, wrn, next_wrn;
    logic       oe, next_oe;
    logic [3:0] dq, next_dq;
    logic       op_rd, op_sel;
    logic [3:0] op_dat;
    logic       acc, wr_cmd;
    logic [31:0] next_prdata;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_s <= '0;
            d_s1 <= ZERO4;
            d_s2 <= ZERO4;
        end else begin
            irq_s <= {irq_s[0], bus.interrupt_or_tone_pin_n_oe};
            d_s1  <= bus.dev_d_out;
            d_s2  <= d_s1;
        end
    end

    assign acc = psel & penable;
    assign wr_cmd = acc & pwrite & (paddr == OFS_CMD) & ~busy;
    assign pready = 1'b1;
    assign pslverr = acc & ~(paddr == OFS_CMD || paddr == OFS_WDATA ||
                             paddr == OFS_STATUS || paddr == OFS_RDATA);
    assign busy = (hst != TTH_H_IDLE);

    // read data is captured in the setup cycle and stands in access
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            unique case (paddr)
                OFS_CMD:    next_prdata = {28'h0, busy, cmd};
                OFS_WDATA:  next_prdata = {28'h0, wdat};
                OFS_STATUS: next_prdata = {27'h0, irq_s[1], stat};
                OFS_RDATA:  next_prdata = {28'h0, rxd};
                default:    next_prdata = '0;
            endcase
        end
    end

    // current port operation per command step
    always_comb begin
        op_rd = 1'b0;
        op_sel = 1'b1;
        op_dat = ZERO4;
        unique case (cmd)
            CMD_RD_STATUS: op_rd = 1'b1;
            CMD_WR_CTRL:   op_dat = wdat;
            CMD_WR_TX: begin
                op_sel = 1'b0;
                op_dat = wdat;
            end
            CMD_RD_RX: begin
                op_rd = 1'b1;
                op_sel = 1'b0;
            end
            CMD_INIT: begin
                op_rd = (step == 3'h0) || (step == 3'h5);
                op_dat = (step == 3'h3) ? CTRL_INIT_B : ZERO4;
            end
            CMD_BURST_CFG:
                op_dat = (step == 3'h0) ? CTRL_A_BURST : ZERO4;
            default: op_rd = 1'b1;
        endcase
    end

    always_comb begin
        next_hst = hst;
        next_bst = bst;
        next_cmd = cmd;
        next_step = step;
        next_wdat = wdat;
        next_stat = stat;
        next_rxd = rxd;
        next_cyc = cyc;
        next_rs = rs;
        next_rdn = rdn;
        next_wrn = wrn;
        next_oe = oe;
        next_dq = dq;
        if (acc && pwrite && paddr == OFS_WDATA && !busy)
            next_wdat = pwdata[3:0];
        unique case (hst)
            TTH_H_IDLE: if (wr_cmd) begin
                next_cmd = pwdata[2:0];
                next_step = '0;
                next_hst = TTH_H_RUN;
                next_bst = TTH_IDLE;
            end
            TTH_H_RUN: unique case (bst)
                TTH_IDLE: begin
                    next_rs = op_sel;
                    next_oe = ~op_rd;
                    next_dq = op_dat;
                    next_cyc = STROBE_CYC[3:0];
                    next_bst = TTH_SET;
                end
                TTH_SET: begin
                    next_rdn = ~op_rd;
                    next_wrn = op_rd;
                    next_bst = TTH_STRB;
                end
                TTH_STRB: if (cyc == '0) begin
                    if (op_rd && op_sel) next_stat = d_s2;
                    if (op_rd && !op_sel) next_rxd = d_s2;
                    next_rdn = 1'b1;
                    next_wrn = 1'b1;
                    next_cyc = STROBE_CYC[3:0];
                    next_bst = TTH_GAP;
                end else next_cyc = cyc - 4'h1;
                TTH_GAP: if (cyc == '0) begin
                    next_oe = 1'b0;
                    next_bst = TTH_IDLE;
                    if ((cmd == CMD_INIT && step != 3'h5) ||
                        (cmd == CMD_BURST_CFG && step == 3'h0))
                        next_step = step + 3'h1;
                    else
                        next_hst = TTH_H_DONE;
                end else next_cyc = cyc - 4'h1;
            endcase
            TTH_H_DONE: next_hst = TTH_H_IDLE;
            default: next_hst = TTH_H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hst <= TTH_H_IDLE;
            bst <= TTH_IDLE;
            cmd <= '0;
            step <= '0;
            wdat <= ZERO4;
            stat <= ZERO4;
            rxd <= ZERO4;
            cyc <= ZERO4;
            rs <= 1'b1;
            rdn <= 1'b1;
            wrn <= 1'b1;
            oe <= 1'b0;
            dq <= ZERO4;
            prdata <= '0;
        end else begin
            hst <= next_hst;
            bst <= next_bst;
            cmd <= next_cmd;
            step <= next_step;
            wdat <= next_wdat;
            stat <= next_stat;
            rxd <= next_rxd;
            cyc <= next_cyc;
            rs <= next_rs;
            rdn <= next_rdn;
            wrn <= next_wrn;
            oe <= next_oe;
            dq <= next_dq;
            prdata <= next_prdata;
        end
    end

    assign bus.register_select_line = rs;
    assign bus.rd_n = rdn;
    assign bus.wr_n = wrn;
    assign bus.host_d_out = dq;
    assign bus.host_d_oe = oe;
endmodule // tth_host
`default_nettype wire

// file: tth_if.sv
// parallel microprocessor port between host and transceiver
`timescale 1ns/1ps
`default_nettype none
interface tth_if;
    logic       register_select_line;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] host_d_out;
    logic       host_d_oe;
    logic [3:0] dev_d_out;
    logic       dev_d_oe;
    logic       interrupt_or_tone_pin_n_oe;
    modport dev (input register_select_line, rd_n, wr_n, host_d_out,
                 host_d_oe, output dev_d_out, dev_d_oe,
                 interrupt_or_tone_pin_n_oe);
    modport host (output register_select_line, rd_n, wr_n, host_d_out,
                  host_d_oe, input dev_d_out, dev_d_oe,
                  interrupt_or_tone_pin_n_oe);
endinterface
`default_nettype wire

// file: tth_pkg.sv
// shared constants and types for the tone transceiver host port
package tth_pkg;
    localparam int DATA_W = 4;
    // event flag bit positions
    localparam int FLAG_IRQ   = 0;
    localparam int FLAG_TXE   = 1;
    localparam int FLAG_RXF   = 2;
    localparam int FLAG_SETTL = 3;
    // control register a bits
    localparam int CA_TONE  = 0;
    localparam int CA_CP    = 1;
    localparam int CA_IRQEN = 2;
    localparam int CA_BSEL  = 3;
    // control register b bits
    localparam int CB_BURST_OFF = 0;
    localparam logic [3:0] ZERO4 = 4'h0;
    localparam logic [3:0] CTRL_A_BURST = 4'hD;
    localparam logic [3:0] CTRL_INIT_B  = 4'h8;
    // burst timing
    localparam int CLK_MHZ       = 100;
    localparam int BURST_MS      = 51;
    localparam int BURST_CP_MS   = 102;
    localparam int BURST_CYC     = BURST_MS * 1000 * CLK_MHZ;
    localparam int BURST_CP_CYC  = BURST_CP_MS * 1000 * CLK_MHZ;
    localparam int CNT_W         = 32;
    // host apb register offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_WDATA  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RDATA  = 8'h0C;
    // host command codes
    localparam logic [2:0] CMD_RD_STATUS = 3'h1;
    localparam logic [2:0] CMD_WR_CTRL   = 3'h2;
    localparam logic [2:0] CMD_WR_TX     = 3'h3;
    localparam logic [2:0] CMD_RD_RX     = 3'h4;
    localparam logic [2:0] CMD_INIT      = 3'h5;
    localparam logic [2:0] CMD_BURST_CFG = 3'h6;
    // strobe must outlast both two-flop paths before read data is taken
    localparam int STROBE_CYC = 5;
    typedef enum logic [1:0] {TTH_IDLE, TTH_SET, TTH_STRB, TTH_GAP}
        tth_bus_t;
    typedef enum logic [1:0] {TTH_B_IDLE, TTH_B_TONE, TTH_B_PAUSE}
        tth_burst_t;
endpackage
